// ===== inc/ars_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the auto-reclose sequencer.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ARS_OFF_CTRL 8'h00
`define ARS_OFF_ACT 8'h04
`define ARS_OFF_RECL 8'h08
`define ARS_OFF_CLOSE 8'h0c
`define ARS_OFF_DYN 8'h10
`define ARS_OFF_SHORT 8'h14
`define ARS_OFF_SPEC 8'h18
`define ARS_OFF_STAT 8'h1c
`define ARS_OFF_DEAD0 8'h20
`define ARS_OFF_LAST 8'h3c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ARS_CTRL_MODE 0
`define ARS_CTRL_MON 1
`define ARS_CTRL_NCYC_LO 2
`define ARS_STAT_CYC_LO 12
`define ARS_STAT_OUT_LO 16

// ----------------------------------------
// Reset values (milliseconds, except CTRL which is a bit field)
// ----------------------------------------
`define ARS_RST_CTRL 4'hc
`define ARS_RST_ACT 17'h003e8
`define ARS_RST_RECL 17'h007d0
`define ARS_RST_CLOSE 17'h00064
`define ARS_RST_DYN 17'h005dc
`define ARS_RST_SHORT 17'h000c8
`define ARS_RST_SPEC 17'h00546
`define ARS_RST_D1P1 17'h001f4
`define ARS_RST_D1P2 17'h00258
`define ARS_RST_D1P3 17'h002bc
`define ARS_RST_D1P4 17'h00320
`define ARS_RST_D3P1 17'h003e8
`define ARS_RST_D3P2 17'h007d0
`define ARS_RST_D3P3 17'h00bb8
`define ARS_RST_D3P4 17'h00fa0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ARS_TICK_MS 1
`define ARS_CLK_PERIOD_PS 5000
`define ARS_TICK_CYC ((`ARS_TICK_MS * 1000000000) / `ARS_CLK_PERIOD_PS)
`define ARS_TW 17

`endif

// ===== inc/ars_pkg.sv
/*
  Types of the auto-reclose sequencer: states and bundled port groups.
  Assumes the defines header is available for widths.
*/
`include "ars_defines.svh"
package ars_pkg;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [8:0] {
        ARS_IDLE  = 9'h001,
        ARS_ACT   = 9'h002,
        ARS_TRIP  = 9'h004,
        ARS_DEAD  = 9'h008,
        ARS_CLOSE = 9'h010,
        ARS_RECL  = 9'h020,
        ARS_FIN   = 9'h040,
        ARS_DYN   = 9'h080,
        ARS_NR    = 9'h100
    } ars_state_e;

    // ----------------------------------------
    // AHB-Lite slave request and response
    // ----------------------------------------
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ars_ahb_req_s;

    typedef struct packed {
        logic hreadyout;
        logic [31:0] hrdata;
        logic hresp;
    } ars_ahb_rsp_s;

    // ----------------------------------------
    // Protection side inputs and sequencer outputs
    // ----------------------------------------
    typedef struct packed {
        logic pickup_in;
        logic ar_launch_in;
        logic three_pole_trip_in;
        logic special_first_dead_in;
        logic breaker_open_in;
        logic sync_permit_in;
        logic operator_close_in;
        logic breaker_ok_in;
        logic dead_delay_in;
        logic shortened_dead_in;
        logic ext_block_in;
    } ars_prot_in_s;

    typedef struct packed {
        logic close_pulse_out;
        logic final_trip_out;
        logic inhibited_out;
        logic in_progress_out;
    } ars_out_s;

endpackage

// ===== core/ars_timer.sv
/*
  Millisecond down-counter used for every interval of the sequencer.
  Assumes a one-cycle tick per millisecond from the parent.
*/
`timescale 1ns/1ps
module ars_timer #(
    parameter int W = 17
) (
    input wire logic clk, // Block clock
    input wire logic reset, // Synchronous, active high
    input wire logic tick, // One-cycle millisecond strobe
    input wire logic start, // Load and run
    input wire logic [W-1:0] load, // Duration in ms
    output logic run // High while counting
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic run_reg;
    logic run_next;

    // ----------------------------------------
    // Count down on ticks; zero load expires at once
    // ----------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (start) begin
            cnt_next = load;
            run_next = (load != '0);
        end else if (run_reg && tick) begin
            cnt_next = cnt_reg - W'(1);
            if (cnt_reg == W'(1)) begin
                run_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    assign run = run_reg;
endmodule

// ===== core/ars_seq.sv
/*
  Auto-reclose sequencer with AHB-Lite register slave.
  Assumes protection inputs synchronous to clk and a single-slave AHB-Lite bus.
*/
`timescale 1ns/1ps
`include "ars_defines.svh"
module ars_seq #(
    parameter int TICK_CYCLES = `ARS_TICK_CYC
) (
    input wire logic clk, // 200 MHz block clock
    input wire logic reset, // Synchronous, active high
    input wire ars_pkg::ars_ahb_req_s ahb_req, // Bus request
    output ars_pkg::ars_ahb_rsp_s ahb_rsp, // Bus response
    input wire ars_pkg::ars_prot_in_s prot, // Protection and breaker inputs
    output ars_pkg::ars_out_s seq_out // Sequencer outputs
);
    import ars_pkg::*;

    localparam int TW = `ARS_TW;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (TICK_CYCLES < 1 || TICK_CYCLES > 262144) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [17:0] div_reg, div_next;
    logic tick_reg, tick_next;

    // Free-running divider; tick is one cycle wide
    always_comb begin
        div_next = div_reg + 18'h00001;
        tick_next = 1'b0;
        if (div_reg == 18'(TICK_CYCLES - 1)) begin
            div_next = 18'h00000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_reg <= 18'h00000;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ----------------------------------------
    // Setting registers
    // ----------------------------------------
    logic [3:0] ctrl_reg, ctrl_next;
    logic [TW-1:0] act_reg, act_next;
    logic [TW-1:0] recl_reg, recl_next;
    logic [TW-1:0] close_reg, close_next;
    logic [TW-1:0] dyn_reg, dyn_next;
    logic [TW-1:0] short_reg, short_next;
    logic [TW-1:0] spec_reg, spec_next;
    logic [TW-1:0] dead_reg [0:7], dead_next [0:7];

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic wr_pend_reg, wr_pend_next;
    logic [5:0] wa_reg, wa_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg;
    logic [31:0] stat_word;
    logic [5:0] ra;
    logic take;
    ars_state_e st_reg;
    logic [2:0] cyc_reg;
    ars_out_s out_reg;

    assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    assign ra = ahb_req.haddr[7:2];
    assign stat_word = {12'h000, out_reg, 1'b0, cyc_reg, 3'h0, st_reg};

    // Address phase captured; read data prepared so it stands in the data phase
    always_comb begin
        wr_pend_next = take && ahb_req.hwrite;
        wa_next = take ? ra : wa_reg;
        rdata_next = 32'h00000000;
        if (take && !ahb_req.hwrite) begin
            case (ra)
                6'(`ARS_OFF_CTRL >> 2): rdata_next = {28'h0000000, ctrl_reg};
                6'(`ARS_OFF_ACT >> 2): rdata_next = {15'h0000, act_reg};
                6'(`ARS_OFF_RECL >> 2): rdata_next = {15'h0000, recl_reg};
                6'(`ARS_OFF_CLOSE >> 2): rdata_next = {15'h0000, close_reg};
                6'(`ARS_OFF_DYN >> 2): rdata_next = {15'h0000, dyn_reg};
                6'(`ARS_OFF_SHORT >> 2): rdata_next = {15'h0000, short_reg};
                6'(`ARS_OFF_SPEC >> 2): rdata_next = {15'h0000, spec_reg};
                6'(`ARS_OFF_STAT >> 2): rdata_next = stat_word;
                // Dead time words fill word indices 8 to 15
                default: rdata_next = (ra[5:3] == 3'h1) ? {15'h0000, dead_reg[ra[2:0]]} : 32'h0;
            endcase
        end
    end

    // Writes land in the data phase; unmapped and status writes are dropped
    always_comb begin
        ctrl_next = ctrl_reg;
        act_next = act_reg;
        recl_next = recl_reg;
        close_next = close_reg;
        dyn_next = dyn_reg;
        short_next = short_reg;
        spec_next = spec_reg;
        for (int i = 0; i < 8; i++) begin
            dead_next[i] = dead_reg[i];
            if (wr_pend_reg && wa_reg == 6'(8 + i)) begin
                dead_next[i] = ahb_req.hwdata[TW-1:0];
            end
        end
        if (wr_pend_reg) begin
            case (wa_reg)
                6'(`ARS_OFF_CTRL >> 2): ctrl_next = ahb_req.hwdata[3:0];
                6'(`ARS_OFF_ACT >> 2): act_next = ahb_req.hwdata[TW-1:0];
                6'(`ARS_OFF_RECL >> 2): recl_next = ahb_req.hwdata[TW-1:0];
                6'(`ARS_OFF_CLOSE >> 2): close_next = ahb_req.hwdata[TW-1:0];
                6'(`ARS_OFF_DYN >> 2): dyn_next = ahb_req.hwdata[TW-1:0];
                6'(`ARS_OFF_SHORT >> 2): short_next = ahb_req.hwdata[TW-1:0];
                6'(`ARS_OFF_SPEC >> 2): spec_next = ahb_req.hwdata[TW-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wa_reg <= 6'h00;
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b1;
            ctrl_reg <= `ARS_RST_CTRL;
            act_reg <= `ARS_RST_ACT;
            recl_reg <= `ARS_RST_RECL;
            close_reg <= `ARS_RST_CLOSE;
            dyn_reg <= `ARS_RST_DYN;
            short_reg <= `ARS_RST_SHORT;
            spec_reg <= `ARS_RST_SPEC;
            dead_reg[0] <= `ARS_RST_D1P1;
            dead_reg[1] <= `ARS_RST_D1P2;
            dead_reg[2] <= `ARS_RST_D1P3;
            dead_reg[3] <= `ARS_RST_D1P4;
            dead_reg[4] <= `ARS_RST_D3P1;
            dead_reg[5] <= `ARS_RST_D3P2;
            dead_reg[6] <= `ARS_RST_D3P3;
            dead_reg[7] <= `ARS_RST_D3P4;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wa_reg <= wa_next;
            rdata_reg <= rdata_next;
            ready_reg <= 1'b1;
            ctrl_reg <= ctrl_next;
            act_reg <= act_next;
            recl_reg <= recl_next;
            close_reg <= close_next;
            dyn_reg <= dyn_next;
            short_reg <= short_next;
            spec_reg <= spec_next;
            dead_reg <= dead_next;
        end
    end

    assign ahb_rsp.hreadyout = ready_reg;
    assign ahb_rsp.hrdata = rdata_reg;
    assign ahb_rsp.hresp = 1'b0;

    // ----------------------------------------
    // Interval timers
    // ----------------------------------------
    logic go_act, go_dead, go_close, go_recl, go_dyn;
    logic act_run, dead_run, close_run, recl_run, dyn_run;
    logic [TW-1:0] dead_load;

    ars_timer #(.W(TW)) u_act (.clk(clk), .reset(reset), .tick(tick_reg), .start(go_act),
        .load(act_reg), .run(act_run));
    ars_timer #(.W(TW)) u_dead (.clk(clk), .reset(reset), .tick(tick_reg), .start(go_dead),
        .load(dead_load), .run(dead_run));
    ars_timer #(.W(TW)) u_close (.clk(clk), .reset(reset), .tick(tick_reg), .start(go_close),
        .load(close_reg), .run(close_run));
    ars_timer #(.W(TW)) u_recl (.clk(clk), .reset(reset), .tick(tick_reg), .start(go_recl),
        .load(recl_reg), .run(recl_run));
    ars_timer #(.W(TW)) u_dyn (.clk(clk), .reset(reset), .tick(tick_reg), .start(go_dyn),
        .load(dyn_reg), .run(dyn_run));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    ars_state_e st_next;
    logic [2:0] cyc_next;
    logic ph3_reg, ph3_next;
    logic seen_reg, seen_next;
    logic pk_reg, pk_next;
    logic trip_q_reg, pick_q_reg;
    ars_out_s out_next;
    logic trip_rise, trip_fall, pick_rise, start_cond, last_cyc, mode_open, mon_en;
    logic [2:0] ncyc;

    assign trip_rise = prot.ar_launch_in && !trip_q_reg;
    assign trip_fall = !prot.ar_launch_in && trip_q_reg;
    assign pick_rise = prot.pickup_in && !pick_q_reg;
    assign mode_open = ctrl_reg[`ARS_CTRL_MODE];
    assign mon_en = ctrl_reg[`ARS_CTRL_MON];
    assign ncyc = {1'b0, ctrl_reg[`ARS_CTRL_NCYC_LO +: 2]} + 3'h1;
    assign last_cyc = (cyc_reg >= ncyc);
    assign start_cond = mode_open ? prot.breaker_open_in : trip_fall;

    // Dead time picked by cycle and fault type; shortened input overrides when short time is less
    always_comb begin
        dead_load = dead_reg[{ph3_reg, cyc_reg[1:0]}];
        if (prot.shortened_dead_in && short_reg < dead_load) begin
            dead_load = short_reg;
        end else if (cyc_reg == 3'h0 && ph3_reg && prot.special_first_dead_in) begin
            dead_load = spec_reg;
        end
    end

    // Next state; a trip decides between next cycle and final trip
    always_comb begin
        st_next = st_reg;
        cyc_next = cyc_reg;
        ph3_next = ph3_reg;
        seen_next = seen_reg;
        pk_next = pk_reg;
        go_act = 1'b0;
        go_dead = 1'b0;
        go_close = 1'b0;
        go_recl = 1'b0;
        go_dyn = 1'b0;
        case (st_reg)
            ARS_IDLE: begin
                cyc_next = 3'h0;
                if (pick_rise) begin
                    st_next = ARS_ACT;
                    go_act = 1'b1;
                end else if (trip_rise) begin
                    st_next = ARS_TRIP;
                    seen_next = 1'b0;
                    ph3_next = prot.three_pole_trip_in;
                end
            end
            ARS_ACT: begin
                if (trip_rise) begin
                    st_next = last_cyc ? ARS_FIN : ARS_TRIP;
                    seen_next = 1'b0;
                    ph3_next = prot.three_pole_trip_in;
                end else if (!act_run) begin
                    st_next = ARS_DYN;
                    go_dyn = 1'b1;
                end
            end
            ARS_TRIP: begin
                seen_next = seen_reg || start_cond;
                if ((seen_reg || start_cond) && !prot.dead_delay_in) begin
                    st_next = ARS_DEAD;
                    go_dead = 1'b1;
                end
            end
            ARS_DEAD: begin
                if (trip_rise) begin
                    st_next = ARS_FIN;
                end else if (!dead_run && prot.sync_permit_in && prot.breaker_ok_in) begin
                    st_next = ARS_CLOSE;
                    go_close = 1'b1;
                    go_recl = 1'b1;
                    cyc_next = cyc_reg + 3'h1;
                    pk_next = 1'b0;
                end
            end
            ARS_CLOSE, ARS_RECL: begin
                if (pick_rise) begin
                    pk_next = 1'b1;
                end
                if (trip_rise) begin
                    st_next = last_cyc ? ARS_FIN : ARS_TRIP;
                    seen_next = 1'b0;
                    ph3_next = prot.three_pole_trip_in;
                end else if (st_reg == ARS_CLOSE && !close_run) begin
                    st_next = recl_run ? ARS_RECL : ARS_IDLE;
                end else if (st_reg == ARS_RECL && !recl_run) begin
                    if (pk_reg || pick_rise) begin
                        st_next = ARS_ACT;
                        go_act = 1'b1;
                    end else begin
                        st_next = ARS_IDLE;
                    end
                end
            end
            ARS_FIN: begin
                if (!prot.ar_launch_in) begin
                    st_next = ARS_DYN;
                    go_dyn = 1'b1;
                end
            end
            ARS_DYN: begin
                if (!dyn_run) begin
                    if (mon_en && mode_open && prot.breaker_open_in) begin
                        st_next = ARS_NR;
                    end else begin
                        st_next = ARS_IDLE;
                    end
                end
            end
            ARS_NR: begin
                if (!(mon_en && mode_open && prot.breaker_open_in)) begin
                    st_next = ARS_IDLE;
                end
            end
            default: st_next = ARS_IDLE;
        endcase
        // Manual close blocks for the dynamic time, external block aborts all
        if (prot.operator_close_in && st_reg != ARS_DYN && st_reg != ARS_NR) begin
            st_next = ARS_DYN;
            go_dyn = 1'b1;
        end
        if (prot.ext_block_in) begin
            st_next = ARS_IDLE;
        end
    end

    // Outputs follow the next state so they come straight from flops
    always_comb begin
        out_next.close_pulse_out = (st_next == ARS_CLOSE);
        out_next.final_trip_out = (st_next == ARS_FIN);
        out_next.inhibited_out = prot.ext_block_in || st_next == ARS_DYN
            || st_next == ARS_NR;
        out_next.in_progress_out = st_next == ARS_TRIP || st_next == ARS_DEAD
            || st_next == ARS_CLOSE || st_next == ARS_RECL
            || (st_next == ARS_ACT && cyc_next != 3'h0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= ARS_IDLE;
            cyc_reg <= 3'h0;
            ph3_reg <= 1'b0;
            seen_reg <= 1'b0;
            pk_reg <= 1'b0;
            trip_q_reg <= 1'b0;
            pick_q_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            st_reg <= st_next;
            cyc_reg <= cyc_next;
            ph3_reg <= ph3_next;
            seen_reg <= seen_next;
            pk_reg <= pk_next;
            trip_q_reg <= prot.ar_launch_in;
            pick_q_reg <= prot.pickup_in;
            out_reg <= out_next;
        end
    end

    assign seq_out = out_reg;
endmodule

// ===== tb/ars_seq_monitor.sv
/* Port checker for the reclose sequencer.
   Assumes it is bound onto ars_seq, one clock, sync reset. */
`timescale 1ns/1ps
module ars_seq_monitor #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk, // Block clock
    input wire logic reset, // Sync reset
    input wire ars_pkg::ars_ahb_req_s ahb_req, // Bus request
    input wire ars_pkg::ars_ahb_rsp_s ahb_rsp, // Bus response
    input wire ars_pkg::ars_prot_in_s prot, // Protection inputs
    input wire ars_pkg::ars_out_s seq_out // Outputs
);
    import ars_pkg::*;
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_block_inhibit: assert property (
        prot.ext_block_in |=> seq_out.inhibited_out) else $error("block not shown");
    chk_block_idle: assert property (
        prot.ext_block_in [*3] |-> !seq_out.in_progress_out && !seq_out.close_pulse_out)
        else $error("ran while blocked");
    chk_sync_hold: assert property (
        $rose(seq_out.close_pulse_out) |->
        $past(prot.sync_permit_in, 1) || $past(prot.sync_permit_in, 2))
        else $error("closed while asynchronous");
    chk_fin_block: assert property (
        $fell(seq_out.final_trip_out) |-> seq_out.inhibited_out)
        else $error("no block after final trip");
    chk_close_prog: assert property (
        seq_out.close_pulse_out |-> seq_out.in_progress_out) else $error("close idle");
    chk_fin_excl: assert property (
        seq_out.final_trip_out |-> !seq_out.close_pulse_out) else $error("close at final");
    chk_fin_release: assert property (
        !prot.ar_launch_in [*3] |-> !seq_out.final_trip_out) else $error("final held");
    chk_fin_cause: assert property (
        $rose(seq_out.final_trip_out) |-> $past(prot.ar_launch_in, 1)
        || $past(prot.ar_launch_in, 2)) else $error("final without trip");
    chk_reset_quiet: assert property (
        $past(reset) |-> seq_out == '0) else $error("outputs after reset");
    // Main scenarios seen at least once
    cov_close: cover property ($rose(seq_out.close_pulse_out));
    cov_final: cover property ($rose(seq_out.final_trip_out));
    cov_inhib: cover property ($rose(seq_out.inhibited_out));
endmodule
bind ars_seq ars_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk(clk), .reset(reset),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .prot(prot), .seq_out(seq_out));

// ===== tb/ars_breaker_model.sv
/* Breaker model: opens on trip, closes on the close pulse.
   Assumes trip and close are levels sampled on clk. */
`timescale 1ns/1ps
module ars_breaker_model #(
    parameter int RDY_DLY = 3
) (
    input wire logic clk, // Block clock
    input wire logic reset, // Sync reset
    input wire logic trip, // Trip command
    input wire logic close, // Close pulse
    output logic open_o, // Open contact
    output logic ready_o // Mechanism charged
);
    int cnt;
    // Trip wins; ready drops while the spring recharges after a close
    always_ff @(posedge clk) begin
        if (reset) begin
            open_o <= 1'b0;
            cnt <= 0;
        end else begin
            open_o <= trip ? 1'b1 : (close ? 1'b0 : open_o);
            cnt <= close ? RDY_DLY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
    assign ready_o = (cnt == 0);
endmodule

// ===== tb/tb_ars_seq.sv
/* Self-checking bench of the reclose sequencer.
   Assumes 1 ms is 10 clocks through TICK_CYCLES. */
`timescale 1ns/1ps
module tb_ars_seq;
    import ars_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic pk = 0, tr = 0, tp = 0, syn = 1, dd = 0, sd = 0, blk = 0, dp = 0, bo, bk;
    logic sf = 0, oc = 0;
    ars_ahb_req_s mreq = '0;
    ars_ahb_req_s breq;
    ars_ahb_rsp_s rsp;
    ars_out_s so;
    ars_prot_in_s prot;
    int failures = 0, checked = 0, n, d1, d3;
    logic [31:0] eq[$], mq[$];
    always_comb begin
        breq = mreq;
        breq.hready = rsp.hreadyout;
    end
    assign prot = '{pickup_in: pk, ar_launch_in: tr, three_pole_trip_in: tp,
        special_first_dead_in: sf, breaker_open_in: bo, sync_permit_in: syn,
        operator_close_in: oc, breaker_ok_in: bk, dead_delay_in: dd,
        shortened_dead_in: sd, ext_block_in: blk};
    ars_seq #(.TICK_CYCLES(10)) uut (.clk(clk), .reset(reset), .ahb_req(breq),
        .ahb_rsp(rsp), .prot(prot), .seq_out(so));
    ars_breaker_model far (.clk(clk), .reset(reset), .trip(tr),
        .close(so.close_pulse_out), .open_o(bo), .ready_o(bk));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task chk(string nm, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Wait for an output bit, bounded, then compare it
    task wout(int b, logic v, int mx);
        n = 0;
        while (so[b] !== v && n <= mx) begin
            @(posedge clk);
            n++;
        end
        chk("seq_out", so[b], v);
        if (n > mx) close_out();
    endtask
    task rdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rsp.hreadyout === 1'b1) return;
        end
        failures++;
        close_out();
    endtask
    // One AHB single transfer; a read notes what the watcher expects
    task bus(logic [31:0] a, logic w, logic [31:0] d, logic [31:0] e, logic [31:0] m);
        @(posedge clk);
        mreq <= '{hsel: 1'b1, haddr: a, htrans: 2'h2, hwrite: w, hsize: 3'h2,
            hwdata: '0, hready: 1'b0};
        rdy();
        mreq.htrans <= 2'h0;
        mreq.hwdata <= d;
        if (!w) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        dp <= !w;
        rdy();
        dp <= 0;
        mreq.hsel <= 0;
    endtask
    // Read data taken at the edge closing the data phase
    always @(posedge clk) begin
        if (dp) chk("hrdata", rsp.hrdata & mq.pop_front(), eq.pop_front());
        if (dp) chk("hresp", rsp.hresp, 1'b0);
    end
    task trip(logic t);
        @(posedge clk);
        tr <= 1;
        tp <= t;
        repeat (4) @(posedge clk);
        tr <= 0;
    endtask
    initial begin
        void'($urandom(96));
        d1 = 2 + $urandom % 2;
        d3 = 6 + $urandom % 2;
        repeat (8) @(posedge clk);
        reset <= 0;
        bus(32'h00, 0, 0, 32'hc, '1);
        bus(32'h04, 0, 0, 32'h3e8, '1);
        bus(32'h40, 0, 0, 0, '1);
        bus(32'h1c, 0, 0, 32'h1, '1);
        bus(32'h04, 1, 3, 0, 0);
        bus(32'h08, 1, 5, 0, 0);
        bus(32'h0c, 1, 2, 0, 0);
        bus(32'h10, 1, 3, 0, 0);
        bus(32'h14, 1, 1, 0, 0);
        for (int i = 0; i < 4; i++) begin
            bus(32'h20 + 4 * i, 1, d1, 0, 0);
            bus(32'h30 + 4 * i, 1, d3, 0, 0);
        end
        bus(32'h00, 1, 32'h4, 0, 0);
        trip(0);
        wout(3, 1, 400);
        chk("dead", n >= (d1 - 1) * 10 && n <= d1 * 10 + 6, 1);
        wout(3, 0, 400);
        chk("close", n >= 10 && n <= 22, 1);
        wout(0, 0, 1000);
        chk("reclaim", n >= 18 && n <= 52, 1);
        bus(32'h1c, 0, 0, 32'h1, 32'hf71ff);
        trip(1);
        wout(3, 1, 400);
        chk("dead", n >= (d3 - 1) * 10 && n <= d3 * 10 + 6, 1);
        wout(3, 0, 100);
        trip(1);
        wout(3, 1, 400);
        wout(3, 0, 100);
        bus(32'h1c, 0, 0, 32'h10020, 32'hf01ff);
        tr <= 1;
        wout(2, 1, 20);
        tr <= 0;
        wout(1, 1, 20);
        wout(1, 0, 400);
        trip(0);
        repeat (3) @(posedge clk);
        tr <= 1;
        wout(2, 1, 20);
        tr <= 0;
        wout(1, 1, 20);
        wout(1, 0, 400);
        pk <= 1;
        wout(1, 1, 100);
        chk("action", n >= 20 && n <= 40, 1);
        pk <= 0;
        wout(1, 0, 400);
        blk <= 1;
        trip(0);
        repeat (30) @(posedge clk);
        chk("prog", so.in_progress_out, 0);
        blk <= 0;
        syn <= 0;
        trip(0);
        repeat (80) @(posedge clk);
        chk("close", so.close_pulse_out, 0);
        syn <= 1;
        wout(3, 1, 20);
        wout(0, 0, 1000);
        dd <= 1;
        trip(0);
        repeat (80) @(posedge clk);
        chk("close", so.close_pulse_out, 0);
        dd <= 0;
        wout(3, 1, 400);
        chk("dead", n >= (d1 - 1) * 10 && n <= d1 * 10 + 6, 1);
        wout(0, 0, 1000);
        sd <= 1;
        trip(1);
        wout(3, 1, 400);
        chk("short", n <= 16, 1);
        sd <= 0;
        wout(0, 0, 1000);
        bus(32'h18, 1, 4, 0, 0);
        sf <= 1;
        trip(1);
        wout(3, 1, 400);
        chk("spec", n >= 30 && n <= 46, 1);
        sf <= 0;
        wout(0, 0, 1000);
        oc <= 1;
        wout(1, 1, 20);
        oc <= 0;
        wout(1, 0, 400);
        bus(32'h00, 1, 32'h7, 0, 0);
        trip(0);
        @(posedge clk);
        tr <= 1;
        wout(2, 1, 30);
        tr <= 0;
        repeat (60) @(posedge clk);
        bus(32'h1c, 0, 0, 32'h20100, 32'hf01ff);
        bus(32'h00, 1, 32'h4, 0, 0);
        wout(1, 0, 50);
        // Mid-run reset must restore CTRL, monitor enable off again, and clear the outputs
        reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        bus(32'h00, 0, 0, 32'hc, '1);
        chk("reset out", so, 4'h0);
        close_out();
    end
endmodule
